// >>> cimi_defines.svh
// Register offsets, field positions and reset values of the memory interface block
`ifndef CIMI_DEFINES_SVH
`define CIMI_DEFINES_SVH

`define CIMI_ADDR_W 12
`define CIMI_OFS_CTRL 12'h000
`define CIMI_OFS_ALT 12'h004
`define CIMI_OFS_PC 12'h008
`define CIMI_OFS_CMD 12'h00C
`define CIMI_OFS_STAT 12'h010

`define CIMI_CTRL_ADDR_ONLY 0
`define CIMI_CTRL_SER0_EN 1
`define CIMI_CTRL_SER1_EN 2
`define CIMI_CTRL_T2_EN 3
`define CIMI_CTRL_XMEM_EN 4
`define CIMI_CTRL_PIN_SEL 5
`define CIMI_CTRL_RST 8'h00

`define CIMI_ALT_SER0_TX 0
`define CIMI_ALT_SER0_RX 1
`define CIMI_ALT_SER1_TX 2
`define CIMI_ALT_SER1_RX 3
`define CIMI_ALT_T2 4
`define CIMI_ALT_XRD 5
`define CIMI_ALT_XWR 6
`define CIMI_ALT_RST 8'h7F

`define CIMI_CMD_PTR 0
`define CIMI_CMD_IND 1
`define CIMI_CMD_DIR 2
`define CIMI_CMD_RNUM_LO 3
`define CIMI_CMD_WR 6
`define CIMI_CMD_WADDR_LO 8
`define CIMI_CMD_WDATA_LO 16

`define CIMI_PTR_BASE 8'h00
`define CIMI_RAM_MASK_256 8'hFF
`define CIMI_RAM_MASK_128 8'h7F

`endif

// >>> cimi_pkg.sv
// Types shared by the memory interface block
package cimi_pkg;

    typedef enum logic [3:0] {
        PH_C1 = 4'h1,
        PH_C2 = 4'h2,
        PH_C3 = 4'h4,
        PH_C4 = 4'h8
    } cimi_phase_t;

    typedef struct packed {
        logic [7:0] wdata;
        logic [7:0] waddr;
        logic wr;
        logic [2:0] rnum;
        logic dir;
        logic ind;
        logic ptr;
    } cimi_cmd_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] ctrl;
        logic [7:0] alt;
        logic pc_load;
        logic [15:0] pc_val;
        logic cmd_issue;
        cimi_cmd_t cmd;
    } cimi_regs_st_t;

    typedef struct packed {
        cimi_phase_t phase;
        logic pend_v;
        cimi_cmd_t pend;
        cimi_cmd_t cur;
        logic [7:0] ptr_data;
        logic [7:0] ram_addr;
        logic ram_rd_low;
        logic ram_av_low;
        logic ram_dv_low;
        logic [7:0] ram_wdata;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [15:0] pc;
        logic pc_pend;
        logic [15:0] pc_new;
        logic [15:0] rom_addr;
        logic rom_rd_low;
        logic rom_cs_low;
        logic [7:0] rom_data;
        logic rom_valid;
        logic pin_sel;
        logic p0_mem;
        logic p2_mem;
        logic p0_ad;
        logic ale;
        logic ser0_tx;
        logic ser0_rx;
        logic ser1_tx;
        logic ser1_rx;
        logic t2;
        logic xrd_low;
        logic xwr_low;
    } cimi_st_t;

endpackage : cimi_pkg

// >>> cimi_regs.sv
// APB register slave of the memory interface block
`include "cimi_defines.svh"

module cimi_regs (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Block side
    output logic [7:0] ctrl_out,
    output logic [7:0] alt_out,
    output logic pc_load_out,
    output logic [15:0] pc_value_out,
    output logic cmd_issue_out,
    output cimi_pkg::cimi_cmd_t cmd_out,
    input wire logic [31:0] status_in
);

    cimi_pkg::cimi_regs_st_t st_ff;
    cimi_pkg::cimi_regs_st_t nxt_st;
    logic setup;
    logic access;
    logic hit;
    logic [31:0] rdata;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pready = 1'b1;
        nxt_st.pc_load = 1'b0;
        nxt_st.cmd_issue = 1'b0;
        setup = psel_in && !penable_in;
        access = psel_in && penable_in && st_ff.pready;
        hit = 1'b1;
        rdata = 32'h0;
        unique case ({paddr_in[11:2], 2'b00})
            `CIMI_OFS_CTRL: rdata = {24'h0, st_ff.ctrl};
            `CIMI_OFS_ALT: rdata = {24'h0, st_ff.alt};
            `CIMI_OFS_PC: rdata = {16'h0, st_ff.pc_val};
            `CIMI_OFS_CMD: rdata = {8'h0, st_ff.cmd.wdata, st_ff.cmd.waddr, 1'b0, st_ff.cmd.wr,
                                    st_ff.cmd.rnum, st_ff.cmd.dir, st_ff.cmd.ind, st_ff.cmd.ptr};
            `CIMI_OFS_STAT: rdata = status_in;
            default: hit = 1'b0;
        endcase
        if (setup) begin
            nxt_st.pslverr = !hit;
            nxt_st.prdata = hit ? rdata : 32'h0;
        end
        // Writes land only on the access edge of a mapped address
        if (access && pwrite_in && !st_ff.pslverr) begin
            unique case ({paddr_in[11:2], 2'b00})
                `CIMI_OFS_CTRL: nxt_st.ctrl = pwdata_in[7:0];
                `CIMI_OFS_ALT: nxt_st.alt = pwdata_in[7:0];
                `CIMI_OFS_PC: begin
                    nxt_st.pc_val = pwdata_in[15:0];
                    nxt_st.pc_load = 1'b1;
                end
                `CIMI_OFS_CMD: begin
                    nxt_st.cmd.ptr = pwdata_in[`CIMI_CMD_PTR];
                    nxt_st.cmd.ind = pwdata_in[`CIMI_CMD_IND];
                    nxt_st.cmd.dir = pwdata_in[`CIMI_CMD_DIR];
                    nxt_st.cmd.rnum = pwdata_in[`CIMI_CMD_RNUM_LO +: 3];
                    nxt_st.cmd.wr = pwdata_in[`CIMI_CMD_WR];
                    nxt_st.cmd.waddr = pwdata_in[`CIMI_CMD_WADDR_LO +: 8];
                    nxt_st.cmd.wdata = pwdata_in[`CIMI_CMD_WDATA_LO +: 8];
                    nxt_st.cmd_issue = 1'b1;
                end
                default: nxt_st.ctrl = st_ff.ctrl;
            endcase
        end
        if (!access) begin
            nxt_st.pslverr = setup ? !hit : 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
            st_ff.ctrl <= `CIMI_CTRL_RST;
            st_ff.alt <= `CIMI_ALT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata_out = st_ff.prdata;
    assign pready_out = st_ff.pready;
    assign pslverr_out = st_ff.pslverr;
    assign ctrl_out = st_ff.ctrl;
    assign alt_out = st_ff.alt;
    assign pc_load_out = st_ff.pc_load;
    assign pc_value_out = st_ff.pc_val;
    assign cmd_issue_out = st_ff.cmd_issue;
    assign cmd_out = st_ff.cmd;

endmodule : cimi_regs

// >>> cimi_top.sv
// Phase sequencer for the scratch RAM, program ROM and port control outputs
//
// Design decisions made here: the placing of the registers and register access over APB.
`include "cimi_defines.svh"

// Function
// (RULE1) RAM depth parameter: 128 or 256 bytes
// (RULE2) RAM address output always eight bits
// (RULE3) Each RAM read completes in one clock
// (RULE4) Pointer register read in phase two
// (RULE5) Second read in phase three when needed
// (RULE6) Read strobe low two clocks for indirect
// (RULE7) RAM write spans two clock cycles
// (RULE8) Address-valid qualifier low in phase four
// (RULE9) Data-valid qualifier low in next phase one
// (RULE10) Glue enables async RAM mid phase one
// (RULE11) Sync RAM glue latches address on falling edge
// (RULE12) ROM width parameter, default thirteen bits
// (RULE13) ROM address sixteen bits, upper bits zero
// (RULE14) ROM data valid two clocks after strobe
// (RULE15) Address-only ROM: data after three clocks
// (RULE16) Select between port latch and pads
// (RULE17) Port zero and two memory selects
// (RULE18) Port zero address or data select
// (RULE19) External latch uses address latch enable
// (RULE20) Alternate outputs high when peripheral disabled
// (RULE21) Four one-clock phases per instruction cycle
module cimi_top #(
    parameter int RAM_256 = 1,
    parameter int ROM_ADDR_SIZE = 13
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Scratch RAM
    output logic [7:0] ram_addr_out,
    output logic ram_read_strobe_low_out,
    input wire logic [7:0] ram_read_data_in,
    output logic [7:0] ram_write_data_out,
    output logic scratch_ram_addr_valid_low_out,
    output logic scratch_ram_data_valid_low_out,
    // Program ROM
    output logic [15:0] rom_addr_out,
    output logic rom_read_strobe_low_out,
    output logic rom_chip_select_low_out,
    input wire logic [7:0] rom_read_data_in,
    // Results
    output logic [7:0] ram_result_out,
    output logic ram_result_valid_out,
    output logic [7:0] rom_byte_out,
    output logic rom_byte_valid_out,
    // Port module controls
    output logic port_pin_or_latch_out,
    output logic port_zero_memory_select_out,
    output logic port_two_memory_select_out,
    output logic port_zero_addr_or_data_out,
    output logic addr_latch_enable_out,
    // Alternate function outputs
    output logic serial_zero_transmit_out,
    output logic serial_zero_receive_out,
    output logic serial_one_transmit_out,
    output logic serial_one_receive_out,
    output logic timer_two_output_out,
    output logic ext_mem_read_low_out,
    output logic ext_mem_write_low_out
);

    localparam logic [7:0] RAM_MASK = (RAM_256 != 0) ? `CIMI_RAM_MASK_256 : `CIMI_RAM_MASK_128; // [RULE1] [RULE2]
    localparam logic [15:0] ROM_MASK = 16'((32'h1 << ROM_ADDR_SIZE) - 32'h1); // [RULE12]

    logic rst_meta_ff;
    logic rst_sync_ff;
    cimi_pkg::cimi_st_t st_ff;
    cimi_pkg::cimi_st_t nxt_st;
    logic [7:0] ctrl;
    logic [7:0] alt;
    logic pc_load;
    logic [15:0] pc_value;
    logic cmd_issue;
    cimi_pkg::cimi_cmd_t cmd;
    logic [31:0] status;
    logic addr_only;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign status = {11'h0, st_ff.pend_v, st_ff.phase, st_ff.rd_data, st_ff.rom_data};

    cimi_regs u_regs (
        .clk_in(core_clk_in),
        .rst_n_in(rst_sync_ff),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .ctrl_out(ctrl),
        .alt_out(alt),
        .pc_load_out(pc_load),
        .pc_value_out(pc_value),
        .cmd_issue_out(cmd_issue),
        .cmd_out(cmd),
        .status_in(status)
    );

    assign addr_only = ctrl[`CIMI_CTRL_ADDR_ONLY];

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rd_valid = 1'b0;
        nxt_st.rom_valid = 1'b0;
        unique case (st_ff.phase)
            cimi_pkg::PH_C1: nxt_st.phase = cimi_pkg::PH_C2; // [RULE21]
            cimi_pkg::PH_C2: nxt_st.phase = cimi_pkg::PH_C3;
            cimi_pkg::PH_C3: nxt_st.phase = cimi_pkg::PH_C4;
            cimi_pkg::PH_C4: nxt_st.phase = cimi_pkg::PH_C1;
            default: nxt_st.phase = cimi_pkg::PH_C1;
        endcase
        // Outputs are set for the phase being entered
        unique case (nxt_st.phase)
            cimi_pkg::PH_C2: begin
                nxt_st.ram_addr = `CIMI_PTR_BASE | {7'h0, st_ff.cur.ptr}; // [RULE4]
                nxt_st.ram_rd_low = 1'b0;
                nxt_st.ram_dv_low = 1'b1;
            end
            cimi_pkg::PH_C3: begin
                nxt_st.ptr_data = ram_read_data_in; // [RULE3]
                nxt_st.ram_rd_low = !(st_ff.cur.ind || st_ff.cur.dir); // [RULE6]
                if (st_ff.cur.ind) begin
                    nxt_st.ram_addr = ram_read_data_in; // [RULE5]
                end else if (st_ff.cur.dir) begin
                    nxt_st.ram_addr = {5'h0, st_ff.cur.rnum}; // [RULE5]
                end
            end
            cimi_pkg::PH_C4: begin
                nxt_st.ram_rd_low = 1'b1;
                if (st_ff.cur.ind || st_ff.cur.dir) begin
                    nxt_st.rd_data = ram_read_data_in; // [RULE3]
                    nxt_st.rd_valid = 1'b1;
                end
                if (st_ff.cur.wr) begin
                    nxt_st.ram_addr = st_ff.cur.waddr; // [RULE7]
                    nxt_st.ram_wdata = st_ff.cur.wdata;
                    nxt_st.ram_av_low = 1'b0; // [RULE8]
                end
            end
            cimi_pkg::PH_C1: begin
                nxt_st.ram_av_low = 1'b1;
                nxt_st.ram_dv_low = !st_ff.cur.wr; // [RULE9]
                nxt_st.cur = st_ff.pend_v ? st_ff.pend : '0;
                nxt_st.pend_v = 1'b0;
                nxt_st.rom_addr = (st_ff.pc_pend ? st_ff.pc_new : st_ff.pc) & ROM_MASK; // [RULE13]
                nxt_st.pc = 16'(nxt_st.rom_addr + 16'h1) & ROM_MASK;
                nxt_st.pc_pend = 1'b0;
            end
            default: nxt_st.ram_rd_low = 1'b1;
        endcase
        // ROM strobes low in phase one, or always in address-only mode
        nxt_st.rom_rd_low = !((nxt_st.phase == cimi_pkg::PH_C1) || addr_only); // [RULE15]
        nxt_st.rom_cs_low = nxt_st.rom_rd_low;
        if ((!addr_only && st_ff.phase == cimi_pkg::PH_C2) ||
            (addr_only && st_ff.phase == cimi_pkg::PH_C3)) begin
            nxt_st.rom_data = rom_read_data_in; // [RULE14] [RULE15]
            nxt_st.rom_valid = 1'b1;
        end
        nxt_st.ram_addr = nxt_st.ram_addr & RAM_MASK; // [RULE1]
        // A new command or PC load in the consuming cycle wins over the clear
        if (cmd_issue) begin
            nxt_st.pend = cmd;
            nxt_st.pend_v = 1'b1;
        end
        if (pc_load) begin
            nxt_st.pc_new = pc_value;
            nxt_st.pc_pend = 1'b1;
        end
        nxt_st.pin_sel = ctrl[`CIMI_CTRL_PIN_SEL]; // [RULE16]
        nxt_st.p0_mem = ctrl[`CIMI_CTRL_XMEM_EN]; // [RULE17]
        nxt_st.p2_mem = ctrl[`CIMI_CTRL_XMEM_EN];
        nxt_st.ale = ctrl[`CIMI_CTRL_XMEM_EN] && (nxt_st.phase == cimi_pkg::PH_C1); // [RULE19]
        nxt_st.p0_ad = nxt_st.ale; // [RULE18]
        nxt_st.ser0_tx = !ctrl[`CIMI_CTRL_SER0_EN] || alt[`CIMI_ALT_SER0_TX]; // [RULE20]
        nxt_st.ser0_rx = !ctrl[`CIMI_CTRL_SER0_EN] || alt[`CIMI_ALT_SER0_RX];
        nxt_st.ser1_tx = !ctrl[`CIMI_CTRL_SER1_EN] || alt[`CIMI_ALT_SER1_TX];
        nxt_st.ser1_rx = !ctrl[`CIMI_CTRL_SER1_EN] || alt[`CIMI_ALT_SER1_RX];
        nxt_st.t2 = !ctrl[`CIMI_CTRL_T2_EN] || alt[`CIMI_ALT_T2];
        nxt_st.xrd_low = !ctrl[`CIMI_CTRL_XMEM_EN] || alt[`CIMI_ALT_XRD];
        nxt_st.xwr_low = !ctrl[`CIMI_CTRL_XMEM_EN] || alt[`CIMI_ALT_XWR];
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            st_ff <= '0;
            st_ff.phase <= cimi_pkg::PH_C4;
            st_ff.ram_rd_low <= 1'b1;
            st_ff.ram_av_low <= 1'b1;
            st_ff.ram_dv_low <= 1'b1;
            st_ff.rom_rd_low <= 1'b1;
            st_ff.rom_cs_low <= 1'b1;
            st_ff.ser0_tx <= 1'b1;
            st_ff.ser0_rx <= 1'b1;
            st_ff.ser1_tx <= 1'b1;
            st_ff.ser1_rx <= 1'b1;
            st_ff.t2 <= 1'b1;
            st_ff.xrd_low <= 1'b1;
            st_ff.xwr_low <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ram_addr_out = st_ff.ram_addr;
    assign ram_read_strobe_low_out = st_ff.ram_rd_low;
    assign ram_write_data_out = st_ff.ram_wdata;
    assign scratch_ram_addr_valid_low_out = st_ff.ram_av_low;
    assign scratch_ram_data_valid_low_out = st_ff.ram_dv_low;
    assign rom_addr_out = st_ff.rom_addr;
    assign rom_read_strobe_low_out = st_ff.rom_rd_low;
    assign rom_chip_select_low_out = st_ff.rom_cs_low;
    assign ram_result_out = st_ff.rd_data;
    assign ram_result_valid_out = st_ff.rd_valid;
    assign rom_byte_out = st_ff.rom_data;
    assign rom_byte_valid_out = st_ff.rom_valid;
    assign port_pin_or_latch_out = st_ff.pin_sel;
    assign port_zero_memory_select_out = st_ff.p0_mem;
    assign port_two_memory_select_out = st_ff.p2_mem;
    assign port_zero_addr_or_data_out = st_ff.p0_ad;
    assign addr_latch_enable_out = st_ff.ale;
    assign serial_zero_transmit_out = st_ff.ser0_tx;
    assign serial_zero_receive_out = st_ff.ser0_rx;
    assign serial_one_transmit_out = st_ff.ser1_tx;
    assign serial_one_receive_out = st_ff.ser1_rx;
    assign timer_two_output_out = st_ff.t2;
    assign ext_mem_read_low_out = st_ff.xrd_low;
    assign ext_mem_write_low_out = st_ff.xwr_low;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_sync_ff);

    a_phase_ring: assert property ( // [RULE21]
        st_ff.phase == cimi_pkg::PH_C1 |=> st_ff.phase == cimi_pkg::PH_C2 ##1 st_ff.phase == cimi_pkg::PH_C3
            ##1 st_ff.phase == cimi_pkg::PH_C4 ##1 st_ff.phase == cimi_pkg::PH_C1)
        else $error("phase ring broken");

    a_ptr_read_c2: assert property ( // [RULE4]
        st_ff.phase == cimi_pkg::PH_C2 |-> !ram_read_strobe_low_out && ram_addr_out[7:1] == 7'h0)
        else $error("pointer read missing in phase two");

    a_rd_two_clk: assert property ( // [RULE6]
        st_ff.phase == cimi_pkg::PH_C3 && st_ff.cur.ind |-> !ram_read_strobe_low_out
            && $past(!ram_read_strobe_low_out) ##1 ram_read_strobe_low_out)
        else $error("indirect read strobe not two clocks");

    a_direct_addr: assert property ( // [RULE5]
        st_ff.phase == cimi_pkg::PH_C3 && st_ff.cur.dir && !st_ff.cur.ind |->
            ram_addr_out == {5'h0, st_ff.cur.rnum})
        else $error("direct register address wrong");

    a_indirect_addr: assert property ( // [RULE5]
        st_ff.phase == cimi_pkg::PH_C3 && st_ff.cur.ind |-> ram_addr_out == (st_ff.ptr_data & RAM_MASK))
        else $error("indirect address differs from pointer");

    a_read_one_clk: assert property ( // [RULE3]
        st_ff.phase == cimi_pkg::PH_C3 && !ram_read_strobe_low_out |=>
            ram_result_valid_out && ram_result_out == $past(ram_read_data_in))
        else $error("read data not taken after one clock");

    a_write_pair: assert property ( // [RULE7] [RULE8] [RULE9]
        st_ff.phase == cimi_pkg::PH_C4 && st_ff.cur.wr |-> !scratch_ram_addr_valid_low_out
            && scratch_ram_data_valid_low_out ##1 scratch_ram_addr_valid_low_out
            && !scratch_ram_data_valid_low_out && ram_write_data_out == $past(ram_write_data_out))
        else $error("write qualifiers out of order");

    a_av_only_c4: assert property ( // [RULE8]
        !scratch_ram_addr_valid_low_out |-> st_ff.phase == cimi_pkg::PH_C4)
        else $error("address qualifier outside phase four");

    a_ram_upper_off: assert property ( // [RULE1]
        RAM_256 == 0 |-> !ram_addr_out[7])
        else $error("upper RAM half addressed");

    a_rom_upper_zero: assert property ( // [RULE13]
        (rom_addr_out & ~ROM_MASK) == 16'h0)
        else $error("ROM address above width not zero");

    a_rom_strobe_lat: assert property ( // [RULE14]
        !addr_only && $fell(rom_read_strobe_low_out) |-> ##2 rom_byte_valid_out)
        else $error("ROM byte not taken two clocks after strobe");

    a_alt_idle_high: assert property ( // [RULE20]
        $past(!ctrl[`CIMI_CTRL_SER0_EN]) && $past(!ctrl[`CIMI_CTRL_T2_EN]) |->
            serial_zero_transmit_out && serial_zero_receive_out && timer_two_output_out)
        else $error("disabled alternate output not high");

endmodule : cimi_top

// >>> cimi_mem_model.sv
// Behavioural scratch RAM and program ROM with their glue logic
module cimi_mem_model (
    // Clock
    input wire logic clk_in,
    // Scratch RAM
    input wire logic [7:0] ram_addr_in,
    input wire logic ram_rd_low_in,
    input wire logic [7:0] ram_wdata_in,
    input wire logic av_low_in,
    input wire logic dv_low_in,
    output logic [7:0] ram_rdata_out,
    // Program ROM
    input wire logic [15:0] rom_addr_in,
    input wire logic rom_rd_low_in,
    input wire logic rom_cs_low_in,
    input wire logic addr_only_in,
    output logic [7:0] rom_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] lat_addr;
    logic armed = 1'b0;
    logic [15:0] last_addr;
    logic [1:0] age = 2'h0;
    logic [7:0] rom_word;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 7 + 3);
        end
    end
    // Address qualifier seen in the phase before the data qualifier
    always @(posedge clk_in) begin
        armed <= !av_low_in;
    end
    // Address taken on the falling edge, so read data must return within half a clock
    always @(negedge clk_in) begin
        lat_addr <= ram_addr_in;
        if (armed && !dv_low_in) begin
            mem[lat_addr] <= ram_wdata_in;
        end
    end
    // Without the read strobe the data lines carry an inverted byte
    assign ram_rdata_out = ram_rd_low_in ? ~mem[lat_addr] : mem[lat_addr];
    always @(posedge clk_in) begin
        if (rom_addr_in != last_addr || (!rom_rd_low_in && !rom_cs_low_in && !addr_only_in)) begin
            age <= 2'h1;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
        last_addr <= rom_addr_in;
    end
    assign rom_word = rom_addr_in[7:0] ^ 8'h3C;
    // Valid only inside the access window
    assign rom_data_out = (addr_only_in ? age >= 2'h2 : age == 2'h1) ? rom_word : ~rom_word;
endmodule : cimi_mem_model

// >>> tb.sv
// Self-checking bench for the memory interface block
`include "cimi_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] cmd; logic [7:0] res;} cimi_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic addr_only = 1'b0;
    logic mon_on = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, perr, rrd, av, dv, rom_rd, rom_cs, res_v, rom_v, pin, p0m, p2m, p0ad, ale;
    logic [7:0] raddr, rdat, wdat, res, rom_dat, rom_b;
    logic [15:0] rom_addr;
    logic [6:0] alt;
    logic [2:0] rs;
    int mismatches = 0;
    int n_compared = 0;
    cimi_row_t rows [8] = '{'{32'h03, 8'h49}, '{32'h02, 8'h18}, '{32'h2C, 8'h26}, '{32'h3C, 8'h34},
        '{32'h17, 8'h49}, '{32'h5AC45C, 8'h18}, '{32'h77035C, 8'h18}, '{32'h1C, 8'h77}};

    cimi_top i_dut (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .ram_addr_out(raddr), .ram_read_strobe_low_out(rrd), .ram_read_data_in(rdat), .ram_write_data_out(wdat),
        .scratch_ram_addr_valid_low_out(av), .scratch_ram_data_valid_low_out(dv), .rom_addr_out(rom_addr),
        .rom_read_strobe_low_out(rom_rd), .rom_chip_select_low_out(rom_cs), .rom_read_data_in(rom_dat),
        .ram_result_out(res), .ram_result_valid_out(res_v), .rom_byte_out(rom_b), .rom_byte_valid_out(rom_v),
        .port_pin_or_latch_out(pin), .port_zero_memory_select_out(p0m), .port_two_memory_select_out(p2m),
        .port_zero_addr_or_data_out(p0ad), .addr_latch_enable_out(ale), .serial_zero_transmit_out(alt[0]),
        .serial_zero_receive_out(alt[1]), .serial_one_transmit_out(alt[2]), .serial_one_receive_out(alt[3]),
        .timer_two_output_out(alt[4]), .ext_mem_read_low_out(alt[5]), .ext_mem_write_low_out(alt[6]));
    cimi_mem_model i_mem (.clk_in(clk), .ram_addr_in(raddr), .ram_rd_low_in(rrd), .ram_wdata_in(wdat),
        .av_low_in(av), .dv_low_in(dv), .ram_rdata_out(rdat), .rom_addr_in(rom_addr), .rom_rd_low_in(rom_rd),
        .rom_cs_low_in(rom_cs), .addr_only_in(addr_only), .rom_data_out(rom_dat));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wait_c1();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rom_rd !== 1'b0 && n < 8);
    endtask : wait_c1

    task automatic run(input cimi_row_t r);
        int n;
        n = 0;
        apb(1'b1, `CIMI_OFS_CMD, r.cmd);
        do begin
            @(posedge clk);
            n++;
        end while (res_v !== 1'b1 && n < 12);
        chk("ram result", 32'(r.res), 32'(res));
        chk("read strobe", 32'(3'b100), 32'(rs));
        chk("qualifiers c4", 32'({1'b1, ~r.cmd[6]}), 32'({dv, av}));
        if (r.cmd[6]) chk("write c4", 32'(r.cmd[23:8]), 32'({wdat, raddr}));
        @(posedge clk);
        chk("qualifiers c1", 32'({~r.cmd[6], 1'b1}), 32'({dv, av}));
        if (r.cmd[6]) chk("write c1", 32'(r.cmd[23:8]), 32'({wdat, raddr}));
        if (r.cmd[6]) chk("ram cell", 32'(r.cmd[23:16]), 32'(i_mem.mem[r.cmd[15:8]]));
    endtask : run

    always @(posedge clk) begin
        rs <= {rs[1:0], rrd};
        if (mon_on && rom_v === 1'b1) begin
            chk("rom byte", 32'(rom_addr[7:0] ^ 8'h3C), 32'(rom_b));
            chk("rom upper", 32'h0, 32'(rom_addr[15:13]));
            chk("rom strobes", 32'({2{~addr_only}}), 32'({rom_rd, rom_cs}));
        end
    end

    initial begin
        #100us;
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge clk);
        chk("reset state", 32'h0FFF, 32'({pready, rrd, av, dv, rom_rd, rom_cs, alt}));
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, `CIMI_OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, `CIMI_OFS_ALT, 32'h0);
        chk("alt reset", 32'h7F, rd);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped error", 32'h1, 32'(perr));
        chk("unmapped data", 32'h0, rd);
        $display("registers done");
        mon_on <= 1'b1;
        foreach (rows[i]) run(rows[i]);
        apb(1'b0, `CIMI_OFS_STAT, 32'h0);
        chk("status result", 32'h077, 32'({rd[20], rd[15:8]}));
        apb(1'b0, `CIMI_OFS_CMD, 32'h0);
        chk("cmd readback", 32'h1C, rd);
        $display("ram commands done");
        apb(1'b1, `CIMI_OFS_ALT, 32'h0);
        repeat (2) @(posedge clk);
        chk("alt disabled", 32'h7F, 32'(alt));
        apb(1'b1, `CIMI_OFS_CTRL, 32'h3E);
        repeat (2) @(posedge clk);
        chk("alt enabled", 32'h0, 32'(alt));
        chk("port selects", 32'h7, 32'({pin, p0m, p2m}));
        wait_c1();
        chk("c1 address phase", 32'h3, 32'({p0ad, ale}));
        @(posedge clk);
        chk("c2 data phase", 32'h0, 32'({p0ad, ale}));
        $display("port controls done");
        apb(1'b1, `CIMI_OFS_PC, 32'hFFFF);
        wait_c1();
        chk("pc masked", 32'h1FFF, 32'(rom_addr));
        repeat (4) @(posedge clk);
        chk("pc wraps", 32'h0, 32'(rom_addr));
        mon_on <= 1'b0;
        apb(1'b1, `CIMI_OFS_CTRL, 32'h01);
        addr_only <= 1'b1;
        repeat (8) @(posedge clk);
        mon_on <= 1'b1;
        repeat (16) @(posedge clk);
        mon_on <= 1'b0;
        $display("rom modes done");
        report_and_stop();
    end
endmodule : tb
